// >>> rtl/hsq_pkg.sv
// Purpose: Shared constants and types of the homing sequencer
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes:   Velocity width is fixed here because the config struct carries it
package hsq_pkg;
   // ***************************
   // Widths
   // ***************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int VEL_W  = 16;
   localparam int MODE_W = 3;
   // ***************************
   // Register offsets
   // ***************************
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_MODE     = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_FAST     = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_CREEP    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_HOME_POS = 8'h1C;
   // ***************************
   // Field positions
   // ***************************
   localparam int CTRL_START  = 0;
   localparam int CTRL_ABORT  = 1;
   localparam int ST_BUSY     = 0;
   localparam int ST_DONE     = 1;
   localparam int ST_ERR      = 2;
   localparam int ST_HOME     = 3;
   localparam int ST_STATE_LO = 4;
   localparam int IRQ_W       = 2;
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_ERR     = 1;
   // Pin index in the synchroniser
   localparam int PIN_HOME    = 0;
   localparam int PIN_STOPPOS = 1;
   localparam int PIN_STOPNEG = 2;
   localparam int PIN_REF     = 3;
   localparam int PIN_N       = 4;
   // ***************************
   // Modes and reset values
   // ***************************
   localparam logic [MODE_W-1:0] MODE_LIMIT = 3'h2;
   localparam logic [MODE_W-1:0] MODE_3     = 3'h3;
   localparam logic [MODE_W-1:0] MODE_4     = 3'h4;
   localparam logic [MODE_W-1:0] MODE_5     = 3'h5;
   localparam logic [MODE_W-1:0] MODE_6     = 3'h6;
   localparam logic [MODE_W-1:0] MODE_RST   = 3'h2;
   localparam logic [VEL_W-1:0]  FAST_RST   = 16'h0400;
   localparam logic [VEL_W-1:0]  CREEP_RST  = 16'h0040;
   localparam logic [IRQ_W-1:0]  MASK_RST   = 2'h0;
   // ***************************
   // Types
   // ***************************
   typedef enum logic [2:0] {
      HSQ_IDLE  = 3'h0,
      HSQ_SEEK  = 3'h1,
      HSQ_CREEP = 3'h2,
      HSQ_ARMED = 3'h3,
      HSQ_DONE  = 3'h4,
      HSQ_FAULT = 3'h5
   } hsq_state_e;
   typedef struct packed {
      logic [MODE_W-1:0] mode;
      logic [VEL_W-1:0]  fast;
      logic [VEL_W-1:0]  creep;
   } hsq_cfg_s;
endpackage : hsq_pkg

// >>> rtl/hsq_homing_sequencer.sv
// Purpose: Homing sequencer for modes 2 to 6 of a positioning drive
// Assumes: Switch and reference pins are asynchronous, encoder count is on clk
// Notes:   Velocity out is a magnitude, direction travels separately
//
// Operation
// - Mode 2: start positive at fast speed, home switch ignored.
// - Mode 2: positive stop rising edge reverses travel, creep speed follows.
// - Mode 2: latch first reference pulse after positive stop falls.
// - Mode 2: home lies on negative side of positive stop.
// - Modes 3-6: home level at start picks direction and speed.
// - Mode 3, home 0: positive fast, reverse on rise, latch after fall.
// - Mode 3, home 1: negative creep, latch after home changes.
// - Mode 4, home 0: positive creep, latch after home becomes active.
// - Mode 4, home 1: negative fast, reverse on fall, latch after rise.
// - Mode 5, home 1: positive creep, latch after home falls.
// - Mode 5, home 0: negative fast, reverse on rise, latch after fall.
// - Mode 6, home 1: positive fast, reverse on fall, latch after rise.
// - Mode 6, home 0: negative creep, latch after home rises.
// - Mode 3: home is a pulse left of the cam's left edge.
// - Reference input is one pulse per revolution, refining home.
// - Non-selected travel stop during homing raises an error.
// - Positive direction is clockwise, negative anticlockwise.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
module hsq_homing_sequencer #(
   parameter int POS_W = 32
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       clkEn,
   // Register port
   input  wire logic [hsq_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [hsq_pkg::DATA_W-1:0] regWrData,
   input  wire logic                       regWr,
   input  wire logic                       regRd,
   output logic      [hsq_pkg::DATA_W-1:0] regRdData,
   // Switches and encoder
   input  wire logic                       homeSwitchPin,
   input  wire logic                       hardwareTravelStopPos,
   input  wire logic                       hardwareTravelStopNeg,
   input  wire logic                       encRefPin,
   input  wire logic [POS_W-1:0]           encCount,
   // Drive command and status
   output logic      [hsq_pkg::VEL_W-1:0]  velCmd,
   output logic                            dirPositive,
   output logic                            homingBusy,
   output logic                            homingDone,
   output logic                            homingError,
   output logic      [POS_W-1:0]           homePos,
   output logic                            irq
);
   // ***************************
   // Parameter check
   // ***************************
   if (POS_W < 1 || POS_W > hsq_pkg::DATA_W) begin : gBadPos
      $error("POS_W must lie between 1 and the register width");
   end

   // ***************************
   // Pin synchronisers
   // ***************************
   logic [hsq_pkg::PIN_N-1:0] pinMeta;
   logic [hsq_pkg::PIN_N-1:0] pinSync;
   logic [hsq_pkg::PIN_N-1:0] pinPrev;
   wire  [hsq_pkg::PIN_N-1:0] pinRaw = {encRefPin, hardwareTravelStopNeg,
                                        hardwareTravelStopPos, homeSwitchPin};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinMeta <= '0;
         pinSync <= '0;
         pinPrev <= '0;
      end else if (clkEn) begin
         pinMeta <= pinRaw;
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   wire homeLvl = pinSync[hsq_pkg::PIN_HOME];
   wire stopPos = pinSync[hsq_pkg::PIN_STOPPOS];
   wire stopNeg = pinSync[hsq_pkg::PIN_STOPNEG];
   // One rising edge per revolution, so a wide pulse latches once
   wire refRise = pinSync[hsq_pkg::PIN_REF] & ~pinPrev[hsq_pkg::PIN_REF];

   // ***************************
   // Registers and state
   // ***************************
   hsq_pkg::hsq_state_e         state;
   hsq_pkg::hsq_state_e         next_state;
   hsq_pkg::hsq_cfg_s           regCfg;
   hsq_pkg::hsq_cfg_s           cfg;
   logic                        startLvl;
   logic                        reversed;
   logic                        useFast;
   logic [hsq_pkg::IRQ_W-1:0]   irqStat;
   logic [hsq_pkg::IRQ_W-1:0]   irqMask;
   logic                        next_dirPos;
   logic                        next_useFast;
   logic                        next_reversed;
   logic                        next_startLvl;

   // ***************************
   // Register decode
   // ***************************
   wire wrCtrl  = regWr && (regAddr == hsq_pkg::OFF_CTRL);
   wire wrMode  = regWr && (regAddr == hsq_pkg::OFF_MODE);
   wire wrFast  = regWr && (regAddr == hsq_pkg::OFF_FAST);
   wire wrCreep = regWr && (regAddr == hsq_pkg::OFF_CREEP);
   wire wrStat  = regWr && (regAddr == hsq_pkg::OFF_IRQ_STAT);
   wire wrMask  = regWr && (regAddr == hsq_pkg::OFF_IRQ_MASK);

   wire ready    = (state == hsq_pkg::HSQ_IDLE) || (state == hsq_pkg::HSQ_DONE)
                   || (state == hsq_pkg::HSQ_FAULT);
   wire startReq = wrCtrl && regWrData[hsq_pkg::CTRL_START] && ready;
   wire abortReq = wrCtrl && regWrData[hsq_pkg::CTRL_ABORT] && !ready;

   // ***************************
   // Start decisions
   // ***************************
   wire [hsq_pkg::MODE_W-1:0] reqMode = regCfg.mode;
   wire isLimitMode = (reqMode == hsq_pkg::MODE_LIMIT);
   wire isM3        = (reqMode == hsq_pkg::MODE_3);
   wire isM4        = (reqMode == hsq_pkg::MODE_4);
   wire isM5        = (reqMode == hsq_pkg::MODE_5);
   wire isM6        = (reqMode == hsq_pkg::MODE_6);
   wire modeOk      = isLimitMode | isM3 | isM4 | isM5 | isM6;

   // Modes 3/4 search positive from an inactive switch, 5/6 from an active one
   wire startDirPos = isLimitMode
                      | ((isM3 | isM4) & ~homeLvl)
                      | ((isM5 | isM6) & homeLvl);
   // Fast speed only where a reversal on the switch edge follows
   wire startFast   = isLimitMode
                      | (isM3 & ~homeLvl) | (isM4 & homeLvl)
                      | (isM5 & ~homeLvl) | (isM6 & homeLvl);
   // Mode 2 watches the positive stop, so home switch is ignored there
   wire startSense  = isLimitMode ? 1'b0 : homeLvl;

   // ***************************
   // Sequence
   // ***************************
   wire inLimit   = (cfg.mode == hsq_pkg::MODE_LIMIT);
   wire senseLvl  = inLimit ? stopPos : homeLvl;
   wire senseEdge = inLimit ? (stopPos ^ pinPrev[hsq_pkg::PIN_STOPPOS])
                            : (homeLvl ^ pinPrev[hsq_pkg::PIN_HOME]);
   // Only mode 2 selects a stop for reversal; any other stop is a fault
   wire stopHit   = stopNeg | (stopPos & ~inLimit);
   // Edge away from the start level turns the seek round
   wire turnEvt   = senseEdge && (senseLvl != startLvl);
   // After a turn the edge back arms; without one, the edge away arms
   wire armLvl    = reversed ? startLvl : ~startLvl;
   wire armEvt    = senseEdge && (senseLvl == armLvl);

   always_comb begin
      next_state    = state;
      next_dirPos   = dirPositive;
      next_useFast  = useFast;
      next_reversed = reversed;
      next_startLvl = startLvl;
      if (startReq) begin
         next_state    = modeOk ? (startFast ? hsq_pkg::HSQ_SEEK : hsq_pkg::HSQ_CREEP)
                                : hsq_pkg::HSQ_FAULT;
         next_dirPos   = startDirPos;
         next_useFast  = startFast;
         next_reversed = 1'b0;
         next_startLvl = startSense;
      end else if (abortReq) begin
         next_state = hsq_pkg::HSQ_IDLE;
      end else begin
         case (state)
            hsq_pkg::HSQ_SEEK: begin
               if (stopHit) begin
                  next_state = hsq_pkg::HSQ_FAULT;
               end else if (turnEvt) begin
                  next_dirPos   = ~dirPositive;
                  next_useFast  = 1'b0;
                  next_reversed = 1'b1;
                  next_state    = hsq_pkg::HSQ_CREEP;
               end
            end
            hsq_pkg::HSQ_CREEP: begin
               if (stopHit) begin
                  next_state = hsq_pkg::HSQ_FAULT;
               end else if (armEvt) begin
                  next_state = hsq_pkg::HSQ_ARMED;
               end
            end
            hsq_pkg::HSQ_ARMED: begin
               if (stopHit) begin
                  next_state = hsq_pkg::HSQ_FAULT;
               end else if (refRise) begin
                  next_state = hsq_pkg::HSQ_DONE;
               end
            end
            hsq_pkg::HSQ_IDLE,
            hsq_pkg::HSQ_DONE,
            hsq_pkg::HSQ_FAULT: begin
               next_state = state;
            end
            default: begin
               next_state = hsq_pkg::HSQ_IDLE;
            end
         endcase
      end
   end

   wire nextMoving = (next_state == hsq_pkg::HSQ_SEEK) || (next_state == hsq_pkg::HSQ_CREEP)
                     || (next_state == hsq_pkg::HSQ_ARMED);
   wire latchEvt   = (state == hsq_pkg::HSQ_ARMED) && (next_state == hsq_pkg::HSQ_DONE);
   wire faultEvt   = (state != hsq_pkg::HSQ_FAULT) && (next_state == hsq_pkg::HSQ_FAULT);
   hsq_pkg::hsq_cfg_s cfgSel;
   assign cfgSel = startReq ? regCfg : cfg;
   wire [hsq_pkg::VEL_W-1:0] next_vel = !nextMoving ? '0
                                       : (next_useFast ? cfgSel.fast : cfgSel.creep);

   // ***************************
   // Interrupt status
   // ***************************
   wire [hsq_pkg::IRQ_W-1:0] evtVec    = {faultEvt, latchEvt};
   wire [hsq_pkg::IRQ_W-1:0] clrVec    = wrStat ? regWrData[hsq_pkg::IRQ_W-1:0] : '0;
   // An event in the clearing cycle survives the clear
   wire [hsq_pkg::IRQ_W-1:0] next_stat = (irqStat & ~clrVec) | evtVec;
   wire [hsq_pkg::IRQ_W-1:0] next_mask = wrMask ? regWrData[hsq_pkg::IRQ_W-1:0] : irqMask;

   // ***************************
   // Read multiplexer
   // ***************************
   logic [hsq_pkg::DATA_W-1:0] rdMux;
   always_comb begin
      rdMux = '0;
      case (regAddr)
         hsq_pkg::OFF_MODE:     rdMux[hsq_pkg::MODE_W-1:0] = regCfg.mode;
         hsq_pkg::OFF_FAST:     rdMux[hsq_pkg::VEL_W-1:0]  = regCfg.fast;
         hsq_pkg::OFF_CREEP:    rdMux[hsq_pkg::VEL_W-1:0]  = regCfg.creep;
         hsq_pkg::OFF_STATUS: begin
            rdMux[hsq_pkg::ST_BUSY] = homingBusy;
            rdMux[hsq_pkg::ST_DONE] = homingDone;
            rdMux[hsq_pkg::ST_ERR]  = homingError;
            rdMux[hsq_pkg::ST_HOME] = homeLvl;
            rdMux[hsq_pkg::ST_STATE_LO +: 3] = state;
         end
         hsq_pkg::OFF_IRQ_STAT: rdMux[hsq_pkg::IRQ_W-1:0] = irqStat;
         hsq_pkg::OFF_IRQ_MASK: rdMux[hsq_pkg::IRQ_W-1:0] = irqMask;
         hsq_pkg::OFF_HOME_POS: rdMux[POS_W-1:0] = homePos;
         default:               rdMux = '0;
      endcase
   end

   // ***************************
   // Flip-flops
   // ***************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regCfg <= '{mode: hsq_pkg::MODE_RST, fast: hsq_pkg::FAST_RST, creep: hsq_pkg::CREEP_RST};
         irqMask <= hsq_pkg::MASK_RST;
      end else if (clkEn) begin
         if (wrMode) regCfg.mode <= regWrData[hsq_pkg::MODE_W-1:0];
         if (wrFast) regCfg.fast <= regWrData[hsq_pkg::VEL_W-1:0];
         if (wrCreep) regCfg.creep <= regWrData[hsq_pkg::VEL_W-1:0];
         irqMask <= next_mask;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state    <= hsq_pkg::HSQ_IDLE;
         cfg      <= '0;
         startLvl <= 1'b0;
         reversed <= 1'b0;
         useFast  <= 1'b0;
      end else if (clkEn) begin
         state    <= next_state;
         cfg      <= cfgSel;
         startLvl <= next_startLvl;
         reversed <= next_reversed;
         useFast  <= next_useFast;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         velCmd      <= '0;
         dirPositive <= 1'b1;
         homingBusy  <= 1'b0;
         homingDone  <= 1'b0;
         homingError <= 1'b0;
         homePos     <= '0;
         irqStat     <= '0;
         irq         <= 1'b0;
         regRdData   <= '0;
      end else if (clkEn) begin
         velCmd      <= next_vel;
         dirPositive <= next_dirPos;
         homingBusy  <= nextMoving;
         homingDone  <= (next_state == hsq_pkg::HSQ_DONE);
         homingError <= (next_state == hsq_pkg::HSQ_FAULT);
         if (latchEvt) homePos <= encCount;
         irqStat     <= next_stat;
         irq         <= |(next_stat & next_mask);
         regRdData   <= regRd ? rdMux : '0;
      end
   end
endmodule : hsq_homing_sequencer

// >>> verification/hsq_homing_checker_assertions.sv
// Purpose: Port-level checks of the homing sequencer
// Assumes: Register writes seen here match those the design takes
// Notes:   Shadows mirror MODE, CREEP, FAST and the done mask bit
`timescale 1ns/100ps
module hsq_homing_checker (
   // Clock and reset
   input wire logic                       clk,
   input wire logic                       sys_rst,
   input wire logic                       clkEn,
   // Register port
   input wire logic [hsq_pkg::ADDR_W-1:0] regAddr,
   input wire logic [hsq_pkg::DATA_W-1:0] regWrData,
   input wire logic                       regWr,
   // Pins
   input wire logic                       hardwareTravelStopNeg,
   input wire logic                       encRefPin,
   // Drive command and status
   input wire logic [hsq_pkg::VEL_W-1:0]  velCmd,
   input wire logic                       dirPositive,
   input wire logic                       homingBusy,
   input wire logic                       homingDone,
   input wire logic                       homingError,
   input wire logic                       irq
);
   // ****
   // Shadow registers
   // ****
   logic [hsq_pkg::MODE_W-1:0] modeSh;
   logic [hsq_pkg::VEL_W-1:0]  fastSh;
   logic [hsq_pkg::VEL_W-1:0]  creepSh;
   logic [hsq_pkg::VEL_W-1:0]  creepRun;
   logic                       maskDone;
   wire logic wrOn    = clkEn && regWr;
   wire logic startOk = wrOn && regAddr == hsq_pkg::OFF_CTRL && regWrData[hsq_pkg::CTRL_START] && !homingBusy;
   wire logic badMode = modeSh < hsq_pkg::MODE_LIMIT || modeSh > hsq_pkg::MODE_6;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         modeSh   <= hsq_pkg::MODE_RST;
         fastSh   <= hsq_pkg::FAST_RST;
         creepSh  <= hsq_pkg::CREEP_RST;
         creepRun <= hsq_pkg::CREEP_RST;
         maskDone <= 1'b0;
      end else if (clkEn) begin
         if (wrOn && regAddr == hsq_pkg::OFF_MODE) modeSh <= regWrData[hsq_pkg::MODE_W-1:0];
         if (wrOn && regAddr == hsq_pkg::OFF_FAST) fastSh <= regWrData[hsq_pkg::VEL_W-1:0];
         if (wrOn && regAddr == hsq_pkg::OFF_CREEP) creepSh <= regWrData[hsq_pkg::VEL_W-1:0];
         if (wrOn && regAddr == hsq_pkg::OFF_IRQ_MASK) maskDone <= regWrData[hsq_pkg::IRQ_DONE];
         // Creep is frozen at start, so later writes must not reach the drive
         if (startOk) creepRun <= creepSh;
      end
   end
   // ****
   // Assertions
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_MODE2_START:
      assert property (startOk && modeSh == hsq_pkg::MODE_LIMIT |=> homingBusy && dirPositive && velCmd == fastSh)
      else $error("mode 2 start not positive at fast speed");
   AST_REV_CREEP:
      assert property (homingBusy && $past(homingBusy) && $changed(dirPositive) |-> velCmd == creepRun)
      else $error("reversal not at the creep speed taken at start");
   AST_VEL_HELD:
      assert property (homingBusy && $past(homingBusy) && $changed(velCmd) |-> $changed(dirPositive))
      else $error("speed changed without a reversal");
   AST_STOP_FAULT:
      assert property (homingBusy && hardwareTravelStopNeg |-> ##[0:4] homingError)
      else $error("negative stop during homing gave no error");
   AST_IDLE_ZERO:
      assert property (!homingBusy |-> velCmd == '0)
      else $error("speed commanded while not homing");
   AST_DONE_FROM_BUSY:
      assert property ($rose(homingDone) |-> $past(homingBusy) && !homingError)
      else $error("done raised without a homing run");
   AST_REF_DONE:
      assert property ($rose(homingDone) |-> $past(encRefPin, 1) || $past(encRefPin, 2) ||
                       $past(encRefPin, 3) || $past(encRefPin, 4))
      else $error("done without a reference pulse");
   AST_BAD_MODE:
      assert property (startOk && badMode |=> homingError && !homingBusy)
      else $error("invalid mode did not fault");
   AST_IRQ_DONE:
      assert property ($rose(homingDone) && maskDone |-> ##[0:2] irq)
      else $error("unmasked done gave no interrupt");
endmodule : hsq_homing_checker
bind hsq_homing_sequencer hsq_homing_checker hsq_homing_checker_inst (
   .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
   .regWr(regWr), .hardwareTravelStopNeg(hardwareTravelStopNeg), .encRefPin(encRefPin),
   .velCmd(velCmd), .dirPositive(dirPositive), .homingBusy(homingBusy), .homingDone(homingDone),
   .homingError(homingError), .irq(irq));

// >>> verification/hsq_plant.sv
// Purpose: Axis model with drive, encoder, home cam and travel stops
// Assumes: One encoder count per speed unit per clock
// Notes:   No switch bounce; a revolution is 2**REV_LOG counts
`timescale 1ns/100ps
module hsq_plant #(
   parameter int REV_LOG = 14,
   parameter int HOME_LO = 90112,
   parameter int HOME_HI = 139264,
   parameter int STOP_N  = 24576,
   parameter int STOP_P  = 204800
) (
   // Clock
   input  wire logic                      clk,
   // Drive command
   input  wire logic [hsq_pkg::VEL_W-1:0] velCmd,
   input  wire logic                      dirPositive,
   // Position preset
   input  wire logic                      loadPos,
   input  wire logic [31:0]               loadVal,
   // Sensors
   output logic                           homeSwitchPin,
   output logic                           stopPos,
   output logic                           stopNeg,
   output logic                           encRefPin,
   output logic      [31:0]               encCount
);
   logic [31:0] posPrev;
   wire logic [31:0] next_pos = dirPositive ? encCount + velCmd : encCount - velCmd;
   always_ff @(posedge clk) begin
      encCount  <= loadPos ? loadVal : next_pos;
      posPrev   <= encCount;
      // One pulse per boundary crossing in either direction
      encRefPin <= posPrev[31:REV_LOG] != encCount[31:REV_LOG];
   end
   assign homeSwitchPin = encCount >= HOME_LO && encCount < HOME_HI;
   assign stopPos       = encCount >= STOP_P;
   assign stopNeg       = encCount <= STOP_N;
endmodule : hsq_plant

// >>> verification/hsq_homing_sequencer_bench.sv
// Purpose: Self-checking bench of the homing sequencer
// Assumes: Cam at 5.5 to 8.5 turns, stops at 1.5 and 12.5 turns
// Notes:   Home is judged to the nearest revolution boundary
`timescale 1ns/100ps
module hsq_homing_sequencer_bench;
   logic                       clk       = 1'b0;
   logic                       sys_rst   = 1'b1;
   logic [hsq_pkg::ADDR_W-1:0] regAddr   = '0;
   logic [hsq_pkg::DATA_W-1:0] regWrData = '0;
   logic                       regWr     = 1'b0;
   logic                       regRd     = 1'b0;
   logic                       loadPos   = 1'b1;
   logic                       clkEn     = 1'b1;
   logic [31:0]                loadVal   = '0;
   logic [hsq_pkg::DATA_W-1:0] regRdData;
   logic                       homeSw, stopP, stopN, encRef;
   logic [31:0]                encCount, homePos;
   logic [hsq_pkg::VEL_W-1:0]  velCmd;
   logic                       dirPositive, homingBusy, homingDone, homingError, irq;
   int                         err_count = 0;
   int                         checked   = 0;
   // Mode, start in quarter turns, home boundary, direction, fast start
   int tMode[9]  = '{2, 3, 3, 4, 4, 5, 5, 6, 6};
   int tStart[9] = '{13, 9, 29, 17, 29, 31, 45, 25, 41};
   int tIdx[9]   = '{12, 5, 5, 6, 6, 9, 9, 8, 8};
   int tDir[9]   = '{1, 1, 0, 1, 0, 1, 0, 1, 0};
   int tFast[9]  = '{1, 1, 0, 0, 1, 0, 1, 1, 0};
   always #5 clk = ~clk;
   hsq_homing_sequencer hsq_homing_sequencer_inst (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .homeSwitchPin(homeSw), .hardwareTravelStopPos(stopP), .hardwareTravelStopNeg(stopN),
      .encRefPin(encRef), .encCount(encCount), .velCmd(velCmd), .dirPositive(dirPositive),
      .homingBusy(homingBusy), .homingDone(homingDone), .homingError(homingError),
      .homePos(homePos), .irq(irq));
   hsq_plant hsq_plant_inst (.clk(clk), .velCmd(velCmd), .dirPositive(dirPositive), .loadPos(loadPos),
      .loadVal(loadVal), .homeSwitchPin(homeSw), .stopPos(stopP), .stopNeg(stopN),
      .encRefPin(encRef), .encCount(encCount));
   // ****
   // Tasks
   // ****
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (e !== g) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge clk);
      regWr     <= 1'b0;
   endtask : wr
   task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd   <= 1'b0;
      @(posedge clk);
      chk(n, e, regRdData & m);
   endtask : rdChk
   task automatic place(input int q);
      @(posedge clk);
      loadVal <= 32'(q * 4096);
      loadPos <= 1'b1;
      @(posedge clk);
      loadPos <= 1'b0;
      // Let the switch synchronisers see the new position
      repeat (4) @(posedge clk);
   endtask : place
   task automatic startRun(input int mode);
      wr(hsq_pkg::OFF_MODE, 32'(mode));
      wr(hsq_pkg::OFF_CTRL, 32'h1);
   endtask : startRun
   task automatic waitIdle;
      int n;
      n = 0;
      while (homingBusy === 1'b1 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      chk("busy end", 32'h0, 32'(homingBusy));
   endtask : waitIdle
   task automatic runCase(input int i);
      place(tStart[i]);
      startRun(tMode[i]);
      @(posedge clk);
      chk("direction", 32'(tDir[i]), 32'(dirPositive));
      chk("speed", (tFast[i] != 0) ? 32'h300 : 32'h30, 32'(velCmd));
      if (i == 0) wr(hsq_pkg::OFF_CREEP, 32'h20);
      waitIdle();
      chk("done", 32'h1, 32'(homingDone));
      chk("home boundary", 32'(tIdx[i]), (homePos + 32'h2000) >> 14);
      rdChk("status", hsq_pkg::OFF_STATUS, 32'h77, 32'h42);
      if (i == 0) wr(hsq_pkg::OFF_CREEP, 32'h30);
      $display("test mode %0d from %0d quarter turns done", tMode[i], tStart[i]);
   endtask : runCase
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // ****
   // Tests
   // ****
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rdChk("mode reset", hsq_pkg::OFF_MODE, 32'hFFFFFFFF, 32'h2);
      rdChk("fast reset", hsq_pkg::OFF_FAST, 32'hFFFFFFFF, 32'h400);
      rdChk("creep reset", hsq_pkg::OFF_CREEP, 32'hFFFFFFFF, 32'h40);
      rdChk("mask reset", hsq_pkg::OFF_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
      rdChk("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
      wr(hsq_pkg::OFF_FAST, 32'h300);
      wr(hsq_pkg::OFF_CREEP, 32'h30);
      wr(hsq_pkg::OFF_IRQ_MASK, 32'h1);
      for (int i = 0; i < 9; i++) runCase(i);
      chk("irq on done", 32'h1, 32'(irq));
      startRun(7);
      @(posedge clk);
      chk("bad mode error", 32'h1, 32'(homingError));
      $display("test invalid mode done");
      place(12);
      startRun(5);
      waitIdle();
      chk("stop error", 32'h1, 32'(homingError));
      chk("stop speed", 32'h0, 32'(velCmd));
      $display("test stop fault done");
      // A stalled clock enable must swallow the abort write
      place(12);
      startRun(2);
      clkEn <= 1'b0;
      wr(hsq_pkg::OFF_CTRL, 32'h2);
      clkEn <= 1'b1;
      @(posedge clk);
      chk("frozen busy", 32'h1, 32'(homingBusy));
      wr(hsq_pkg::OFF_CTRL, 32'h2);
      @(posedge clk);
      chk("abort busy", 32'h0, 32'(homingBusy));
      chk("abort speed", 32'h0, 32'(velCmd));
      $display("test abort and clock enable done");
      wr(hsq_pkg::OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", 32'h0, 32'(irq));
      rdChk("irq status", hsq_pkg::OFF_IRQ_STAT, 32'h3, 32'h3);
      wr(hsq_pkg::OFF_IRQ_STAT, 32'h3);
      rdChk("irq cleared", hsq_pkg::OFF_IRQ_STAT, 32'h3, 32'h0);
      $display("test interrupts done");
      end_of_test();
   end
   // Watchdog: the run needs well under 20000 cycles
   initial begin
      #500000;
      err_count++;
      end_of_test();
   end
endmodule : hsq_homing_sequencer_bench
